// ===== verilog/oscsel_map.vh
// register map, field positions, reset values and timing of the oscillator select control
`ifndef OSCSEL_MAP_VH
`define OSCSEL_MAP_VH

// byte offsets of the apb registers
`define OSCSEL_CTRL_OFS 8'h00
`define OSCSEL_KEY_OFS 8'h04
`define OSCSEL_STAT_OFS 8'h08
`define OSCSEL_MASK_OFS 8'h0C

// field positions inside oscillator_control
`define OSCSEL_PLLF_LSB 16
`define OSCSEL_ACT_LSB 12
`define OSCSEL_REQ_LSB 8
`define OSCSEL_LOCK_BIT 7
`define OSCSEL_USBL_BIT 6
`define OSCSEL_SYSL_BIT 5
`define OSCSEL_SLP_BIT 4
`define OSCSEL_CF_BIT 3

// reset values
`define OSCSEL_PLLF_RST 3'h0
`define OSCSEL_LOCK_RST 1'b0
`define OSCSEL_SLP_RST 1'b0
`define OSCSEL_MASK_RST 4'h0
`define OSCSEL_SRC_RST 3'h0

// unlock key words, written in this order to the key register
`define OSCSEL_KEY_A 32'h5A5A0F0F
`define OSCSEL_KEY_B 32'hA5A5F0F0

// interrupt event positions in status and mask
`define OSCSEL_EV_DONE 0
`define OSCSEL_EV_FAIL 1
`define OSCSEL_EV_LOCKLOSS 2
`define OSCSEL_EV_REJECT 3
`define OSCSEL_EV_W 4

// source codes that run through the system pll
`define OSCSEL_SRC_FAST_RC_WITH_MULTIPLIER 3'h1
`define OSCSEL_SRC_PRIPLL 3'h3

// least settle time of the clock mux before a switch may commit
`define OSCSEL_CLK_NS 8
`define OSCSEL_SETTLE_NS 200
`define OSCSEL_SETTLE_CYC ((`OSCSEL_SETTLE_NS + `OSCSEL_CLK_NS - 1) / `OSCSEL_CLK_NS)

`endif

// ===== verilog/oscsel_switch.v
// clock source switch sequencer: drives the mux select and tracks the active source
`timescale 1ns/100ps
`default_nettype none
`include "oscsel_map.vh"
module oscsel_switch #(
  parameter CNT_W = 8,
  parameter [CNT_W-1:0] SETTLE = `OSCSEL_SETTLE_CYC
) (
  input wire clk,
  input wire rst_n,
  input wire init_load,
  input wire [2:0] init_code,
  input wire [2:0] requested,
  input wire pll_locked,
  input wire mux_ack,
  output reg [2:0] active_r,
  output reg [2:0] mux_sel_r,
  output reg busy_r,
  output reg done_r
);
  localparam ST_IDLE = 2'b00;
  localparam ST_SETTLE = 2'b01;
  localparam ST_ACK = 2'b10;

  reg [1:0] state_r;
  reg [CNT_W-1:0] cnt_r;
  reg [2:0] target_r;

  // pll-based sources must not be committed before the pll is usable
  function uses_pll;
    input [2:0] code;
    begin
      uses_pll = (code == `OSCSEL_SRC_FAST_RC_WITH_MULTIPLIER) || (code == `OSCSEL_SRC_PRIPLL);
    end
  endfunction

  // switch sequence: select, wait settle time, wait mux ack (and pll), then commit
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      cnt_r <= {CNT_W{1'b0}};
      target_r <= `OSCSEL_SRC_RST;
      active_r <= `OSCSEL_SRC_RST;
      mux_sel_r <= `OSCSEL_SRC_RST;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (init_load) begin
        // startup source is live straight out of reset, no switch needed
        state_r <= ST_IDLE;
        active_r <= init_code;
        mux_sel_r <= init_code;
        target_r <= init_code;
        busy_r <= 1'b0;
      end else begin
        case (state_r)
          ST_IDLE: begin
            if (requested != active_r) begin
              target_r <= requested;
              mux_sel_r <= requested;
              cnt_r <= SETTLE;
              busy_r <= 1'b1;
              state_r <= ST_SETTLE;
            end
          end
          ST_SETTLE: begin
            if (cnt_r <= 1) begin
              state_r <= ST_ACK;
            end else begin
              cnt_r <= cnt_r - 1'b1;
            end
          end
          ST_ACK: begin
            if (mux_ack && (pll_locked || !uses_pll(target_r))) begin
              active_r <= target_r;
              done_r <= 1'b1;
              busy_r <= 1'b0;
              state_r <= ST_IDLE;
            end
          end
          default: begin
            state_r <= ST_IDLE;
            busy_r <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ===== verilog/oscsel_ctrl.v
// oscillator select control: apb registers, unlock, lock, status flags and interrupt
`timescale 1ns/100ps
`default_nettype none
`include "oscsel_map.vh"
module oscsel_ctrl #(
  parameter ADDR_W = 8,
  parameter USB_PRESENT = 1
) (
  input wire CLK,
  input wire RST_N,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [ADDR_W-1:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  input wire [2:0] STARTUP_SOURCE_CONFIG,
  input wire [1:0] SWITCH_MONITOR_CONFIG,
  input wire SYS_PLL_LOCKED,
  input wire USB_PLL_LOCKED,
  input wire CLOCK_FAIL_DETECT,
  input wire CLK_MUX_ACK,
  output reg [2:0] CLK_SRC_SEL,
  output reg [2:0] PLL_FACTOR_SELECT,
  output reg [4:0] PLL_MULTIPLY,
  output reg SLEEP_ON_WAIT,
  output reg SWITCH_BUSY,
  output reg IRQ
);
  reg rst_s1_r;
  reg rst_s2_r;
  wire rst_n_i;

  // reset is asserted at once and released through two flops
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  assign rst_n_i = rst_s2_r;

  // pin inputs pass two flops; only the second stage is read by logic
  reg [2:0] cfg_s1_r;
  reg [2:0] cfg_s2_r;
  reg [1:0] mon_s1_r;
  reg [1:0] mon_s2_r;
  reg [3:0] pin_s1_r;
  reg [3:0] pin_s2_r;
  reg sysl_d_r;
  reg fail_d_r;
  always @(posedge CLK or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_s1_r <= 3'h0;
      cfg_s2_r <= 3'h0;
      mon_s1_r <= 2'h0;
      mon_s2_r <= 2'h0;
      pin_s1_r <= 4'h0;
      pin_s2_r <= 4'h0;
      sysl_d_r <= 1'b0;
      fail_d_r <= 1'b0;
    end else begin
      cfg_s1_r <= STARTUP_SOURCE_CONFIG;
      cfg_s2_r <= cfg_s1_r;
      mon_s1_r <= SWITCH_MONITOR_CONFIG;
      mon_s2_r <= mon_s1_r;
      pin_s1_r <= {CLK_MUX_ACK, CLOCK_FAIL_DETECT, USB_PLL_LOCKED, SYS_PLL_LOCKED};
      pin_s2_r <= pin_s1_r;
      sysl_d_r <= pin_s2_r[0];
      fail_d_r <= pin_s2_r[2];
    end
  end
  wire sys_locked = pin_s2_r[0];
  wire usb_locked = pin_s2_r[1] & (USB_PRESENT != 0);
  wire fail_seen = pin_s2_r[2];
  wire mux_ack = pin_s2_r[3];

  // startup strap is caught once it has crossed both sync stages
  reg [1:0] init_cnt_r;
  reg init_load_r;
  always @(posedge CLK or negedge rst_n_i) begin
    if (!rst_n_i) begin
      init_cnt_r <= 2'h0;
      init_load_r <= 1'b0;
    end else begin
      init_load_r <= (init_cnt_r == 2'h1);
      if (init_cnt_r != 2'h3) begin
        init_cnt_r <= init_cnt_r + 2'h1;
      end
    end
  end

  // multiplier value of each factor code
  function [4:0] mult_of;
    input [2:0] code;
    begin
      case (code)
        3'h7: mult_of = 5'h18;
        default: mult_of = {2'h0, code} + 5'h0F;
      endcase
    end
  endfunction

  // register index of an address, 3'h7 when unmapped
  function [2:0] reg_sel;
    input [ADDR_W-1:0] addr;
    begin
      case (addr[7:0])
        `OSCSEL_CTRL_OFS: reg_sel = 3'h0;
        `OSCSEL_KEY_OFS: reg_sel = 3'h1;
        `OSCSEL_STAT_OFS: reg_sel = 3'h2;
        `OSCSEL_MASK_OFS: reg_sel = 3'h3;
        default: reg_sel = 3'h7;
      endcase
      if (ADDR_W > 8 && (addr >> 8) != 0) begin
        reg_sel = 3'h7;
      end
    end
  endfunction

  // apb phases: one wait cycle, the write lands on the edge with pready high
  wire acc_first = PSEL & PENABLE & ~PREADY;
  wire acc_done = PSEL & PENABLE & PREADY;
  wire [2:0] sel = reg_sel(PADDR);
  wire wr_done = acc_done & PWRITE;

  reg [2:0] pllf_r;
  reg [2:0] req_r;
  reg lock_r;
  reg slp_r;
  reg cf_r;
  reg [1:0] key_stage_r;
  reg [`OSCSEL_EV_W-1:0] stat_r;
  reg [`OSCSEL_EV_W-1:0] mask_r;
  wire [2:0] active;
  wire sw_busy;
  wire sw_done;
  wire [2:0] mux_sel;

  // monitor config 1x honours the lock bit, 0x never locks
  wire frozen = lock_r & mon_s2_r[1];
  wire armed = (key_stage_r == 2'h2);
  wire ctrl_wr = wr_done & (sel == 3'h0);
  wire ctrl_ok = ctrl_wr & armed;
  wire fail_rise = fail_seen & ~fail_d_r;

  // oscillator_control read image; unimplemented bits stay zero
  wire [31:0] ctrl_img = ({29'h0, pllf_r} << `OSCSEL_PLLF_LSB)
    | ({29'h0, active} << `OSCSEL_ACT_LSB)
    | ({29'h0, req_r} << `OSCSEL_REQ_LSB)
    | ({31'h0, lock_r} << `OSCSEL_LOCK_BIT)
    | ({31'h0, usb_locked} << `OSCSEL_USBL_BIT)
    | ({31'h0, sys_locked} << `OSCSEL_SYSL_BIT)
    | ({31'h0, slp_r} << `OSCSEL_SLP_BIT)
    | ({31'h0, cf_r} << `OSCSEL_CF_BIT);

  // control fields; a write without the key sequence is dropped
  always @(posedge CLK or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pllf_r <= `OSCSEL_PLLF_RST;
      req_r <= `OSCSEL_SRC_RST;
      lock_r <= `OSCSEL_LOCK_RST;
      slp_r <= `OSCSEL_SLP_RST;
      cf_r <= 1'b0;
    end else begin
      if (init_load_r) begin
        req_r <= cfg_s2_r;
      end else if (ctrl_ok && !frozen) begin
        pllf_r <= PWDATA[`OSCSEL_PLLF_LSB+2:`OSCSEL_PLLF_LSB];
        req_r <= PWDATA[`OSCSEL_REQ_LSB+2:`OSCSEL_REQ_LSB];
      end
      if (ctrl_ok) begin
        lock_r <= PWDATA[`OSCSEL_LOCK_BIT];
        slp_r <= PWDATA[`OSCSEL_SLP_BIT];
      end
      // a failure in the clearing cycle still sets the flag
      if (fail_seen) begin
        cf_r <= 1'b1;
      end else if (ctrl_ok && !PWDATA[`OSCSEL_CF_BIT]) begin
        cf_r <= 1'b0;
      end
    end
  end

  // key sequence arms exactly one control write; a wrong word starts over
  always @(posedge CLK or negedge rst_n_i) begin
    if (!rst_n_i) begin
      key_stage_r <= 2'h0;
    end else if (wr_done) begin
      if (sel == 3'h1) begin
        if (PWDATA == `OSCSEL_KEY_A) begin
          key_stage_r <= 2'h1;
        end else if (key_stage_r == 2'h1 && PWDATA == `OSCSEL_KEY_B) begin
          key_stage_r <= 2'h2;
        end else begin
          key_stage_r <= 2'h0;
        end
      end else begin
        key_stage_r <= 2'h0;
      end
    end
  end

  // sticky events; a status read clears only the bits it returned
  reg [`OSCSEL_EV_W-1:0] ev;
  reg [`OSCSEL_EV_W-1:0] clr;
  reg [`OSCSEL_EV_W-1:0] stat_nxt;
  always @* begin
    ev = {`OSCSEL_EV_W{1'b0}};
    ev[`OSCSEL_EV_DONE] = sw_done;
    ev[`OSCSEL_EV_FAIL] = fail_rise;
    ev[`OSCSEL_EV_LOCKLOSS] = sysl_d_r & ~sys_locked;
    ev[`OSCSEL_EV_REJECT] = ctrl_wr & ~armed;
    clr = {`OSCSEL_EV_W{1'b0}};
    if (acc_done && !PWRITE && sel == 3'h2) begin
      clr = PRDATA[`OSCSEL_EV_W-1:0];
    end
    stat_nxt = (stat_r & ~clr) | ev;
  end

  always @(posedge CLK or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stat_r <= {`OSCSEL_EV_W{1'b0}};
      mask_r <= `OSCSEL_MASK_RST;
      IRQ <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      if (wr_done && sel == 3'h3) begin
        mask_r <= PWDATA[`OSCSEL_EV_W-1:0];
      end
      IRQ <= |(stat_nxt & mask_r);
    end
  end

  // apb answer: data and error are set up on the first access edge
  always @(posedge CLK or negedge rst_n_i) begin
    if (!rst_n_i) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0;
      PSLVERR <= 1'b0;
    end else if (acc_first) begin
      PREADY <= 1'b1;
      PSLVERR <= (sel == 3'h7);
      case (sel)
        3'h0: PRDATA <= PWRITE ? 32'h0 : ctrl_img;
        3'h2: PRDATA <= PWRITE ? 32'h0 : {{(32-`OSCSEL_EV_W){1'b0}}, stat_r};
        3'h3: PRDATA <= PWRITE ? 32'h0 : {{(32-`OSCSEL_EV_W){1'b0}}, mask_r};
        default: PRDATA <= 32'h0; // key register is write-only
      endcase
    end else begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end
  end

  // source switching runs apart so a slow mux never stalls the bus
  oscsel_switch u_switch (
    .clk(CLK),
    .rst_n(rst_n_i),
    .init_load(init_load_r),
    .init_code(cfg_s2_r),
    .requested(req_r),
    .pll_locked(sys_locked),
    .mux_ack(mux_ack),
    .active_r(active),
    .mux_sel_r(mux_sel),
    .busy_r(sw_busy),
    .done_r(sw_done)
  );

  // outputs are re-registered so every top port comes from a flop
  always @(posedge CLK or negedge rst_n_i) begin
    if (!rst_n_i) begin
      CLK_SRC_SEL <= `OSCSEL_SRC_RST;
      PLL_FACTOR_SELECT <= `OSCSEL_PLLF_RST;
      PLL_MULTIPLY <= 5'h0F;
      SLEEP_ON_WAIT <= `OSCSEL_SLP_RST;
      SWITCH_BUSY <= 1'b0;
    end else begin
      CLK_SRC_SEL <= mux_sel;
      PLL_FACTOR_SELECT <= pllf_r;
      PLL_MULTIPLY <= mult_of(pllf_r);
      SLEEP_ON_WAIT <= slp_r;
      SWITCH_BUSY <= sw_busy;
    end
  end
endmodule
`default_nettype wire

// ===== verilog/oscsel_dummy_unused.v
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// ===== tb/oscsel_ctrl_assertions.sv
// port checker for the oscillator select control
`timescale 1ns/100ps
`default_nettype none
module oscsel_chk #(
  parameter ADDR_W = 8
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [2:0] PLL_FACTOR_SELECT,
  input wire logic [4:0] PLL_MULTIPLY,
  input wire logic SLEEP_ON_WAIT
);
  // completed transfers, any and write only
  wire logic acc = PSEL && PENABLE && PREADY;
  wire logic wacc = acc && PWRITE;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  // own decode of the factor, so a shared slip cannot hide
  function automatic logic [4:0] mul(input logic [2:0] c);
    mul = (c == 3'h7) ? 5'h18 : 5'h0F + c;
  endfunction
  a_rdy_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready held too long");
  a_rdy_second: assert property (PSEL && $rose(PENABLE) |=> PREADY)
    else $error("ready late");
  a_err_unmapped: assert property (PSEL && $rose(PENABLE) && PADDR > 8'h0C |=> PSLVERR)
    else $error("unmapped access not flagged");
  a_err_mapped: assert property (PREADY && PADDR <= 8'h0C && PADDR[1:0] == 2'h0 |-> !PSLVERR)
    else $error("mapped access flagged");
  // code and multiplier leave the same register edge, so they agree in every cycle
  a_mul_map: assert property (PLL_MULTIPLY == mul(PLL_FACTOR_SELECT))
    else $error("multiplier wrong");
  a_ctl_reserved: assert property (
    acc && !PWRITE && PADDR == 8'h00 |-> PRDATA[31:19] == 13'h0 && !PRDATA[15] && !PRDATA[11])
    else $error("reserved bits set");
  a_fac_by_write: assert property (
    $changed(PLL_FACTOR_SELECT) |-> $past(wacc) || $past(wacc, 2))
    else $error("factor moved without write");
  a_slp_by_write: assert property (
    $changed(SLEEP_ON_WAIT) |-> $past(wacc) || $past(wacc, 2))
    else $error("sleep moved without write");
  c_ctl_read: cover property (acc && !PWRITE && PADDR == 8'h00);
  c_unmapped: cover property (acc && PSLVERR);
  c_top_factor: cover property (PLL_MULTIPLY == 5'h18);
endmodule
bind oscsel_ctrl oscsel_chk #(.ADDR_W(ADDR_W)) u_chk (
  .CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .PLL_FACTOR_SELECT(PLL_FACTOR_SELECT), .PLL_MULTIPLY(PLL_MULTIPLY),
  .SLEEP_ON_WAIT(SLEEP_ON_WAIT)
);
`default_nettype wire

// ===== tb/oscsel_ctrl_tb.sv
// self-checking bench for the oscillator select control
`timescale 1ns/100ps
`default_nettype none
`include "oscsel_map.vh"
module oscsel_ctrl_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] pa = 8'h00;
  logic [31:0] pwd = 32'h0;
  logic [31:0] prd;
  logic rdy, err, lerr, slp, busy, irq;
  logic sysl = 1'b1;
  logic usbl = 1'b1;
  logic cfd = 1'b0;
  logic ack = 1'b1;
  logic [1:0] mon = 2'h0;
  logic [2:0] strap = 3'h0;
  logic [2:0] sel, fsel, act, rq;
  logic [2:0] f = 3'h0;
  logic [4:0] mul;
  logic lk = 1'b0;
  logic sl = 1'b0;
  logic cf = 1'b0;
  int num_errors = 0;
  int total_checks = 0;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  always #4 clk = ~clk;
  oscsel_ctrl dut (
    .CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(pa),
    .PWDATA(pwd), .PRDATA(prd), .PREADY(rdy), .PSLVERR(err),
    .STARTUP_SOURCE_CONFIG(strap), .SWITCH_MONITOR_CONFIG(mon), .SYS_PLL_LOCKED(sysl),
    .USB_PLL_LOCKED(usbl), .CLOCK_FAIL_DETECT(cfd), .CLK_MUX_ACK(ack),
    .CLK_SRC_SEL(sel), .PLL_FACTOR_SELECT(fsel), .PLL_MULTIPLY(mul),
    .SLEEP_ON_WAIT(slp), .SWITCH_BUSY(busy), .IRQ(irq)
  );
  task automatic results();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // expected control word from the bench's own copy of the fields
  function automatic logic [31:0] ectl();
    ectl = {13'h0, f, 1'b0, act, 1'b0, rq, lk, usbl, sysl, sl, cf, 3'h0};
  endfunction
  // one apb transfer; holds everything until ready is seen at an edge
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pa <= a;
    pwr <= w;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 20);
    lerr = err;
    psel <= 1'b0;
    pen <= 1'b0;
    if (n >= 20) begin
      num_errors++;
      results();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    apb(a, 1'b0, 32'h0);
  endtask
  // key pair then the control write it arms
  task automatic uw(input logic [31:0] d);
    apb(8'h04, 1'b1, `OSCSEL_KEY_A);
    apb(8'h04, 1'b1, `OSCSEL_KEY_B);
    apb(8'h00, 1'b1, d);
  endtask
  // busy may rise late, so look for it first, then its end
  task automatic wait_sw();
    int n;
    n = 0;
    while (busy !== 1'b1 && n < 10) begin
      @(negedge clk);
      n++;
    end
    while (busy !== 1'b0 && n < 300) begin
      @(negedge clk);
      n++;
    end
    if (n >= 300) begin
      num_errors++;
      results();
    end
  endtask
  // read data is judged at the edge that completes the read
  always @(posedge clk) begin
    if (psel && pen && rdy === 1'b1 && !pwr && exp_q.size() > 0) begin
      chk(prd & msk_q[0], exp_q[0]);
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  end
  initial begin
    void'($urandom(32'hDC9F));
    strap <= 3'($urandom);
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    act = strap;
    rq = strap;
    rd(8'h00, ectl(), 32'hFFFFFFFF);
    @(negedge clk);
    chk({27'h0, mul}, 32'hF);
    chk({29'h0, sel}, {29'h0, strap});
    $display("test reset done");
    apb(8'h00, 1'b1, ectl() ^ 32'h70010);
    rd(8'h00, ectl(), 32'hFFFFFFFF);
    rd(8'h08, 32'h8, 32'h8);
    $display("test refuse done");
    for (int i = 0; i < 8; i++) begin
      f = 3'(i);
      uw(ectl());
      repeat (3) @(negedge clk);
      chk({29'h0, fsel}, i);
      chk({27'h0, mul}, i == 7 ? 32'h18 : 32'hF + i);
    end
    $display("test factor done");
    apb(8'h0C, 1'b1, 32'h1);
    for (int i = 0; i < 8; i++) begin
      if (i == 7)
        apb(8'h0C, 1'b1, 32'h0);
      rq = act + 3'h1;
      uw(ectl());
      wait_sw();
      act = rq;
      repeat (3) @(negedge clk);
      chk({31'h0, irq}, {31'h0, i != 7});
      chk({29'h0, sel}, {29'h0, rq});
      rd(8'h00, ectl(), 32'hFFFFFFFF);
      rd(8'h08, 32'h1, 32'h1);
      repeat (3) @(negedge clk);
      chk({31'h0, irq}, 32'h0);
    end
    $display("test switch done");
    @(posedge clk);
    mon <= 2'h2;
    lk = 1'b1;
    uw(ectl());
    sl = 1'b1;
    uw(ectl() ^ 32'h50100);
    rd(8'h00, ectl(), 32'hFFFFFFFF);
    chk({31'h0, slp}, 32'h1);
    @(posedge clk);
    mon <= 2'h0;
    f = 3'h2;
    uw(ectl());
    rd(8'h00, ectl(), 32'hFFFFFFFF);
    $display("test lock done");
    @(posedge clk);
    cfd <= 1'b1;
    sysl <= 1'b0;
    usbl <= 1'b0;
    repeat (6) @(posedge clk);
    cf = 1'b1;
    rd(8'h00, ectl(), 32'hFFFFFFFF);
    rd(8'h08, 32'h6, 32'h6);
    rd(8'h10, 32'h0, 32'hFFFFFFFF);
    chk({31'h0, lerr}, 32'h1);
    $display("test fail done");
    // let the watcher take the last read before judging the queue empty
    @(negedge clk);
    chk(exp_q.size(), 32'h0);
    results();
  end
endmodule
`default_nettype wire
